// ---- i2c_ctrl_coef_bank_tb_top.sv ----
`timescale 1ns/1ps
module i2c_ctrl_coef_bank_tb_top;
  logic        i_mclk, i_resetn, hp, ack, scl, low, oe, so, sh, eq, dynamic_range_compressor;
  logic [1:0]  rc;
  logic [6:0]  ca;
  logic [7:0]  vol, trim, b;
  logic [2:0]  bm;
  logic [31:0] cd, rnd, v[4];
  logic [7:0]  q[$];
  int          miscompares, checks;
  wire         sda = !((oe && !so) || low);
  icb_ctrl DUT (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_scl(scl),
    .i_sda(sda), .o_sda_out(so), .o_sda_oe(oe), .i_rate_class(rc),
    .i_headphone_sel(hp), .i_core_addr(ca), .o_core_data(cd),
    .o_all_shutdown(sh), .o_master_volume(vol), .o_osc_trim(trim),
    .o_bank_mode(bm), .o_eq_enable(eq), .o_drc_enable(dynamic_range_compressor));
  icb_master_model M (.i_mclk(i_mclk), .i_sda(sda), .o_scl(scl),
    .o_sda_low(low));
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic logic [31:0] bq(input logic [31:0] x);
    return x & 32'h03ffffff;
  endfunction
  task automatic chk(input string n, input logic [31:0] e, logic [31:0] g);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic word(input logic [31:0] w);
    q = {q, w[31:24], w[23:16], w[15:8], w[7:0]};
  endtask
  task automatic wr(input logic [7:0] sub);
    M.cond(1'b0, 1'b1);
    M.put(8'h6c, ack);
    chk("addr ack", 1, ack);
    M.put(sub, ack);
    chk("sub ack", 1, ack);
    foreach (q[i]) begin
      M.put(q[i], ack);
      chk("data ack", 1, ack);
    end
    M.cond(1'b1, 1'b0);
    q = {};
  endtask
  task automatic rd(input logic [7:0] sub, input int n);
    M.cond(1'b0, 1'b1);
    M.put(8'h6c, ack);
    M.put(sub, ack);
    M.cond(1'b0, 1'b1);
    M.put(8'h6d, ack);
    chk("read ack", 1, ack);
    for (int i = 0; i < n; i++) begin
      M.get(i == n - 1, b);
      q.push_back(b);
    end
    M.cond(1'b1, 1'b0);
  endtask
  task automatic core(input logic [6:0] a, input logic [31:0] e);
    @(posedge i_mclk);
    #1 ca = a;
    repeat (2) @(posedge i_mclk);
    #1 chk("core", e, cd);
  endtask
  task automatic summarize();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    i_mclk = 1'b0;
    forever #20 i_mclk = ~i_mclk;
  end
  initial begin
    repeat (60000) @(posedge i_mclk);
    miscompares++;
    summarize();
  end
  initial begin
    i_resetn = 0; hp = 0; rc = 0; ca = 0; rnd = 32'h0e989ef7;
    miscompares = 0; checks = 0;
    repeat (2) @(posedge i_mclk);
    #1 i_resetn = 1;
    chk("volume", 8'h30, vol);
    chk("bank mode", 3'h0, bm);
    chk("shutdown", 1, sh);
    q = {8'h00};
    wr(8'h1b);
    chk("trim", 8'h00, trim);
    b = {(rnd[6:0] == 7'h36) ? 7'h37 : rnd[6:0], 1'b0};
    M.cond(1'b0, 1'b1);
    M.put(b, ack);
    chk("foreign ack", 0, ack);
    M.put(8'h07, ack);
    chk("ignored ack", 0, ack);
    M.cond(1'b1, 1'b0);
    q = {8'h00, rnd[15:8], rnd[23:16]};
    wr(8'h05);
    chk("shutdown", 0, sh);
    chk("volume", rnd[23:16], vol);
    rd(8'h05, 3);
    chk("read", {8'h00, 8'h00, rnd[23:16]}, {q[0], q[1], q[2]});
    q = {};
    $display("test byte registers done");
    rnd = lfsr(rnd); v[0] = rnd; word(rnd);
    wr(8'h3a);
    rnd = lfsr(rnd); v[1] = rnd; word(rnd); word(~rnd); q.pop_back();
    wr(8'h39);
    core(7'h50, v[1]);
    core(7'h51, v[0]);
    rnd = lfsr(rnd);
    for (int i = 0; i < 5; i++) word(rnd ^ 32'(i));
    wr(8'h29);
    for (int i = 0; i < 4; i++) word(~rnd);
    wr(8'h29);
    for (int i = 0; i < 5; i += 4) core(7'(i), bq(rnd ^ 32'(i)));
    $display("test coefficient words done");
    v[0] = v[1];
    for (int k = 1; k < 4; k++) begin
      q = {8'(k)};
      wr(8'h50);
      chk("bank mode", 3'(k), bm);
      rnd = lfsr(rnd); v[k] = rnd; word(rnd);
      wr(8'h39);
    end
    core(7'h50, v[0]);
    q = {8'h04};
    wr(8'h50);
    for (int k = 0; k < 3; k++) begin
      @(posedge i_mclk);
      #1 rc = 2'(k);
      repeat (200) @(posedge i_mclk);
      core(7'h50, v[k + 1]);
    end
    q = {8'h07};
    wr(8'h50);
    chk("bank mode", 3'h4, bm);
    $display("test banks done");
    for (int h = 1; h >= 0; h--) begin
      @(posedge i_mclk);
      #1 hp = 1'(h);
      repeat (3) @(posedge i_mclk);
      #1 chk("eq drc", {2{~1'(h)}}, {eq, dynamic_range_compressor});
    end
    $display("test headphone done");
    summarize();
  end
endmodule

// ---- icb_ctrl.sv ----
`timescale 1ns/1ps
// ------------------------------------------------------------------
// Overview of operation
// - answer only slave address 0x36
// - no byte limit between start and stop
// - byte registers; coefficients in whole words only
// - reads stream from subaddress while master acks
// - unimplemented read bits return zero
// - filter section needs five words, else dropped
// - mixer gain commits after one full word
// - sequential write advances subaddress per location
// - incomplete last location dropped, earlier kept
// - write address direction 0 gets ack
// - ack subaddress and every written byte
// - read: subaddress write, restart, direction 1
// - three stored coefficient banks by rate
// - bank field 000 writes straight to core
// - codes 001-011 fill bank one to three
// - code 100 reloads core on rate change
// - headphone bypasses speaker eq and compressor
// - clearing shutdown bit leaves all-channel shutdown
// - master volume register, 0x30 is unity
// - never stretch clock, no wait states
// ------------------------------------------------------------------
module icb_ctrl #(
  parameter int BIQUAD_BITS = icb_pkg::BIQUAD_BITS,
  parameter int COEF_WORDS  = icb_pkg::COEF_WORDS,
  parameter int NUM_BANKS   = icb_pkg::NUM_BANKS
) (
  input  wire logic        i_mclk,
  input  wire logic        i_resetn,
  input  wire logic        i_scl,
  input  wire logic        i_sda,
  output logic             o_sda_out,
  output logic             o_sda_oe,
  input  wire logic [1:0]  i_rate_class,
  input  wire logic        i_headphone_sel,
  input  wire logic [6:0]  i_core_addr,
  output logic [31:0]      o_core_data,
  output logic             o_all_shutdown,
  output logic [7:0]       o_master_volume,
  output logic [7:0]       o_osc_trim,
  output logic [2:0]       o_bank_mode,
  output logic             o_eq_enable,
  output logic             o_drc_enable
);

  localparam int          BI_W    = $clog2(NUM_BANKS * COEF_WORDS);
  localparam logic [31:0] BQ_MASK = 32'((33'h1 << BIQUAD_BITS) - 33'h1);
  localparam logic [6:0]  LAST_W  = 7'(COEF_WORDS - 1);

  // ------------------------------------------------------------------
  // pin conditioning and bus events
  // ------------------------------------------------------------------
  logic scl;
  logic sda;
  logic scl_d_reg;
  logic sda_d_reg;

  icb_pin_sync u_scl_sync (
    .i_mclk   (i_mclk),
    .i_resetn (i_resetn),
    .i_pin    (i_scl),
    .o_level  (scl)
  );

  icb_pin_sync u_sda_sync (
    .i_mclk   (i_mclk),
    .i_resetn (i_resetn),
    .i_pin    (i_sda),
    .o_level  (sda)
  );

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      scl_d_reg <= scl;
      sda_d_reg <= sda;
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic start_evt;
  logic stop_evt;

  assign scl_rise  = scl & ~scl_d_reg;
  assign scl_fall  = ~scl & scl_d_reg;
  assign start_evt = scl & scl_d_reg & sda_d_reg & ~sda;
  assign stop_evt  = scl & scl_d_reg & ~sda_d_reg & sda;

  // ------------------------------------------------------------------
  // location helpers
  // ------------------------------------------------------------------
  function automatic logic is_coef(input logic [7:0] sub);
    return (sub >= icb_pkg::COEF_FIRST) && (sub <= icb_pkg::COEF_LAST);
  endfunction

  function automatic logic is_biquad(input logic [7:0] sub);
    return (sub >= icb_pkg::COEF_FIRST) && (sub <= icb_pkg::BIQUAD_LAST);
  endfunction

  // bytes per location: whole words for coefficients
  function automatic logic [4:0] loc_size(input logic [7:0] sub);
    if (is_biquad(sub)) begin
      return icb_pkg::BIQUAD_BYTES;
    end else if (is_coef(sub)) begin
      return icb_pkg::WORD_BYTES;
    end
    return icb_pkg::BYTE_REG;
  endfunction

  function automatic logic [6:0] coef_base(input logic [7:0] sub);
    logic [7:0] off;
    off = 8'h00;
    if (is_biquad(sub)) begin
      off = 8'((sub - icb_pkg::COEF_FIRST) * icb_pkg::BIQUAD_WORDS);
    end else begin
      off = 8'(icb_pkg::MIXER_BASE + (sub - icb_pkg::MIXER_FIRST));
    end
    return off[6:0];
  endfunction

  // ------------------------------------------------------------------
  // serial protocol engine
  // ------------------------------------------------------------------
  icb_pkg::icb_state_type st_reg;
  logic [3:0] cnt_reg;
  logic [7:0] sh_reg;
  logic [7:0] tx_reg;
  logic       addr_phase_reg;
  logic       sub_phase_reg;
  logic       read_reg;
  logic       oe_reg;
  logic [7:0] rd_byte;
  logic       byte_done;

  assign byte_done = scl_fall && (st_reg == icb_pkg::ST_RX)
                     && (cnt_reg == icb_pkg::BITS_PER_ACK);

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      st_reg         <= icb_pkg::ST_IDLE;
      cnt_reg        <= 4'h0;
      sh_reg         <= 8'h00;
      tx_reg         <= 8'h00;
      addr_phase_reg <= 1'b0;
      sub_phase_reg  <= 1'b0;
      read_reg       <= 1'b0;
      oe_reg         <= 1'b0;
    end else if (start_evt) begin
      st_reg         <= icb_pkg::ST_RX;
      cnt_reg        <= 4'h0;
      addr_phase_reg <= 1'b1;
      sub_phase_reg  <= 1'b0;
      oe_reg         <= 1'b0;
    end else if (stop_evt) begin
      st_reg <= icb_pkg::ST_IDLE;
      oe_reg <= 1'b0;
    end else begin
      unique case (st_reg)
        icb_pkg::ST_IDLE, icb_pkg::ST_WAIT: begin
        end
        icb_pkg::ST_RX: begin
          if (scl_rise) begin
            sh_reg  <= {sh_reg[6:0], sda};
            cnt_reg <= cnt_reg + 4'h1;
          end else if (byte_done) begin
            addr_phase_reg <= 1'b0;
            if (addr_phase_reg && sh_reg[7:1] != icb_pkg::SLAVE_ADDR) begin
              st_reg <= icb_pkg::ST_WAIT;
            end else begin
              oe_reg <= 1'b1;
              st_reg <= icb_pkg::ST_ACK_TX;
            end
            if (addr_phase_reg) begin
              read_reg      <= sh_reg[0];
              sub_phase_reg <= ~sh_reg[0];
            end else begin
              sub_phase_reg <= 1'b0;
            end
          end
        end
        icb_pkg::ST_ACK_TX: begin
          if (scl_fall) begin
            cnt_reg <= 4'h0;
            if (read_reg) begin
              tx_reg <= rd_byte;
              oe_reg <= ~rd_byte[7];
              st_reg <= icb_pkg::ST_TX;
            end else begin
              oe_reg <= 1'b0;
              st_reg <= icb_pkg::ST_RX;
            end
          end
        end
        icb_pkg::ST_TX: begin
          if (scl_rise) begin
            cnt_reg <= cnt_reg + 4'h1;
          end else if (scl_fall) begin
            if (cnt_reg == icb_pkg::BITS_PER_ACK) begin
              oe_reg <= 1'b0;
              st_reg <= icb_pkg::ST_ACK_RX;
            end else begin
              tx_reg <= {tx_reg[6:0], 1'b0};
              oe_reg <= ~tx_reg[6];
            end
          end
        end
        icb_pkg::ST_ACK_RX: begin
          if (scl_rise && sda) begin
            st_reg <= icb_pkg::ST_WAIT;
          end else if (scl_fall) begin
            cnt_reg <= 4'h0;
            tx_reg  <= rd_byte;
            oe_reg  <= ~rd_byte[7];
            st_reg  <= icb_pkg::ST_TX;
          end
        end
        default: begin
          st_reg <= icb_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // open drain: only ever pulls low, clock line is never driven
  assign o_sda_out = 1'b0;
  assign o_sda_oe  = oe_reg;

  // ------------------------------------------------------------------
  // write assembly and read pointer
  // ------------------------------------------------------------------
  logic [7:0]  wr_sub_reg;
  logic [4:0]  wr_idx_reg;
  logic [7:0]  rd_sub_reg;
  logic [4:0]  rd_idx_reg;
  logic [31:0] pend_reg [icb_pkg::BQ_MAX_WORDS];
  logic [31:0] cw       [icb_pkg::BQ_MAX_WORDS];
  logic        wr_data_evt;
  logic        commit;
  logic        rd_ack;

  assign wr_data_evt = byte_done && !addr_phase_reg && !sub_phase_reg
                       && !read_reg;
  assign commit      = wr_data_evt && is_coef(wr_sub_reg)
                       && (wr_idx_reg + 5'h1 == loc_size(wr_sub_reg));
  assign rd_ack      = (st_reg == icb_pkg::ST_ACK_RX) && scl_rise && !sda;

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      wr_sub_reg <= 8'h00;
      wr_idx_reg <= 5'h00;
      rd_sub_reg <= 8'h00;
      rd_idx_reg <= 5'h00;
      for (int k = 0; k < icb_pkg::BQ_MAX_WORDS; k++) begin
        pend_reg[k] <= 32'h0000_0000;
      end
    end else begin
      if (start_evt || stop_evt) begin
        wr_idx_reg <= 5'h00;
      end else if (byte_done && sub_phase_reg) begin
        wr_sub_reg <= sh_reg;
        wr_idx_reg <= 5'h00;
        rd_sub_reg <= sh_reg;
        rd_idx_reg <= 5'h00;
      end else if (wr_data_evt) begin
        pend_reg[wr_idx_reg[4:2]] <= {pend_reg[wr_idx_reg[4:2]][23:0], sh_reg};
        if (wr_idx_reg + 5'h1 == loc_size(wr_sub_reg)) begin
          wr_sub_reg <= wr_sub_reg + 8'h01;
          wr_idx_reg <= 5'h00;
        end else begin
          wr_idx_reg <= wr_idx_reg + 5'h01;
        end
      end
      if (rd_ack) begin
        if (rd_idx_reg + 5'h1 == loc_size(rd_sub_reg)) begin
          rd_sub_reg <= rd_sub_reg + 8'h01;
          rd_idx_reg <= 5'h00;
        end else begin
          rd_idx_reg <= rd_idx_reg + 5'h01;
        end
      end
    end
  end

  // final word completes with the byte in the shifter
  always_comb begin
    for (int k = 0; k < icb_pkg::BQ_MAX_WORDS; k++) begin
      cw[k] = (3'(k) == wr_idx_reg[4:2]) ? {pend_reg[k][23:0], sh_reg}
                                          : pend_reg[k];
      if (is_biquad(wr_sub_reg)) begin
        cw[k] = cw[k] & BQ_MASK;
      end
    end
  end

  // ------------------------------------------------------------------
  // byte registers
  // ------------------------------------------------------------------
  logic [7:0] shutdown_reg;
  logic [7:0] volume_reg;
  logic [7:0] trim_reg;
  logic [2:0] bank_mode_reg;

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      shutdown_reg  <= icb_pkg::SHUTDOWN_RESET;
      volume_reg    <= icb_pkg::VOLUME_RESET;
      trim_reg      <= icb_pkg::TRIM_RESET;
      bank_mode_reg <= icb_pkg::BANK_DIRECT;
    end else if (wr_data_evt && !is_coef(wr_sub_reg)) begin
      unique case (wr_sub_reg)
        icb_pkg::SUB_SHUTDOWN:  shutdown_reg <= sh_reg;
        icb_pkg::SUB_VOLUME:    volume_reg   <= sh_reg;
        icb_pkg::SUB_OSC_TRIM:  trim_reg     <= sh_reg;
        icb_pkg::SUB_BANK_CTRL: begin
          if (sh_reg[2:0] <= icb_pkg::BANK_AUTO) begin
            bank_mode_reg <= sh_reg[2:0];
          end
        end
        default: begin
        end
      endcase
    end
  end

  assign o_all_shutdown  = shutdown_reg[icb_pkg::SHUTDOWN_BIT];
  assign o_master_volume = volume_reg;
  assign o_osc_trim      = trim_reg;
  assign o_bank_mode     = bank_mode_reg;

  // ------------------------------------------------------------------
  // coefficient core store, stored banks and automatic reload
  // ------------------------------------------------------------------
  logic [31:0]     core_mem [COEF_WORDS];
  logic [31:0]     bank_mem [NUM_BANKS * COEF_WORDS];
  logic            bank_fill;
  logic [1:0]      fill_bank;
  logic [1:0]      rate_bank;
  logic [6:0]      wr_base;
  logic [BI_W-1:0] fill_base;
  logic [BI_W-1:0] rate_base;
  logic            copy_busy_reg;
  logic [6:0]      copy_idx_reg;
  logic [1:0]      rate_prev_reg;
  logic            auto_d_reg;
  logic            copy_trig;

  assign bank_fill = (bank_mode_reg >= icb_pkg::BANK_FILL1)
                     && (bank_mode_reg <= icb_pkg::BANK_FILL3);
  assign fill_bank = 2'(bank_mode_reg - icb_pkg::BANK_FILL1);
  // three banks: 32k, 44.1/48k, everything else
  assign rate_bank = (i_rate_class == icb_pkg::RATE_32K)    ? 2'h0 :
                     (i_rate_class == icb_pkg::RATE_44_48K) ? 2'h1 : 2'h2;
  assign wr_base   = coef_base(wr_sub_reg);
  assign fill_base = BI_W'(fill_bank * COEF_WORDS);
  assign rate_base = BI_W'(rate_bank * COEF_WORDS);
  assign copy_trig = (bank_mode_reg == icb_pkg::BANK_AUTO)
                     && (!auto_d_reg || rate_bank != rate_prev_reg);

  always_ff @(posedge i_mclk) begin
    if (commit && bank_fill) begin
      for (int k = 0; k < icb_pkg::BQ_MAX_WORDS; k++) begin
        if (3'(k) <= wr_idx_reg[4:2]) begin
          bank_mem[fill_base + BI_W'(wr_base) + BI_W'(k)] <= cw[k];
        end
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (commit && !bank_fill) begin
      for (int k = 0; k < icb_pkg::BQ_MAX_WORDS; k++) begin
        if (3'(k) <= wr_idx_reg[4:2]) begin
          core_mem[7'(wr_base + 7'(k))] <= cw[k];
        end
      end
    end else if (copy_busy_reg) begin
      core_mem[copy_idx_reg] <= bank_mem[rate_base + BI_W'(copy_idx_reg)];
    end
  end

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      copy_busy_reg <= 1'b0;
      copy_idx_reg  <= 7'h00;
      rate_prev_reg <= 2'h0;
      auto_d_reg    <= 1'b0;
    end else begin
      auto_d_reg    <= (bank_mode_reg == icb_pkg::BANK_AUTO);
      rate_prev_reg <= rate_bank;
      if (copy_trig) begin
        copy_busy_reg <= 1'b1;
        copy_idx_reg  <= 7'h00;
      end else if (copy_busy_reg) begin
        copy_busy_reg <= (copy_idx_reg != LAST_W);
        copy_idx_reg  <= copy_idx_reg + 7'h01;
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_core_data  <= 32'h0000_0000;
      o_eq_enable  <= 1'b1;
      o_drc_enable <= 1'b1;
    end else begin
      o_core_data  <= core_mem[i_core_addr];
      o_eq_enable  <= ~i_headphone_sel;
      o_drc_enable <= ~i_headphone_sel;
    end
  end

  // ------------------------------------------------------------------
  // read data selection
  // ------------------------------------------------------------------
  logic [31:0] rd_word;

  always_comb begin
    rd_word = core_mem[7'(coef_base(rd_sub_reg) + 7'(rd_idx_reg[4:2]))];
    rd_byte = 8'h00;
    if (is_coef(rd_sub_reg)) begin
      unique case (rd_idx_reg[1:0])
        2'h0: rd_byte = rd_word[31:24];
        2'h1: rd_byte = rd_word[23:16];
        2'h2: rd_byte = rd_word[15:8];
        2'h3: rd_byte = rd_word[7:0];
      endcase
    end else begin
      unique case (rd_sub_reg)
        icb_pkg::SUB_SHUTDOWN:  rd_byte = shutdown_reg;
        icb_pkg::SUB_VOLUME:    rd_byte = volume_reg;
        icb_pkg::SUB_OSC_TRIM:  rd_byte = trim_reg;
        icb_pkg::SUB_BANK_CTRL: rd_byte = {2'h0, i_rate_class, 1'b0,
                                           bank_mode_reg};
        default:                rd_byte = 8'h00;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  property p_foreign_addr;
    @(posedge i_mclk) disable iff (!i_resetn)
    byte_done && addr_phase_reg && sh_reg[7:1] != icb_pkg::SLAVE_ADDR
    |=> (st_reg == icb_pkg::ST_WAIT) && !o_sda_oe;
  endproperty
  a_foreign_addr: assert property (p_foreign_addr)
    else $error("foreign address was answered");

  property p_own_addr_ack;
    @(posedge i_mclk) disable iff (!i_resetn)
    byte_done && addr_phase_reg && sh_reg[7:1] == icb_pkg::SLAVE_ADDR
    |=> o_sda_oe && (read_reg == $past(sh_reg[0]));
  endproperty
  a_own_addr_ack: assert property (p_own_addr_ack)
    else $error("own address not acknowledged");

  property p_data_ack;
    @(posedge i_mclk) disable iff (!i_resetn)
    byte_done && !addr_phase_reg && !start_evt && !stop_evt
    |=> o_sda_oe ##1 (o_sda_oe || scl_fall || start_evt || stop_evt);
  endproperty
  a_data_ack: assert property (p_data_ack)
    else $error("written byte not acknowledged");

  property p_no_stretch;
    @(posedge i_mclk) disable iff (!i_resetn)
    $changed(o_sda_oe) |-> $past(scl_fall) || $past(start_evt)
                           || $past(stop_evt);
  endproperty
  a_no_stretch: assert property (p_no_stretch)
    else $error("data line moved outside clock low phase");

  property p_core_commit;
    @(posedge i_mclk) disable iff (!i_resetn)
    commit && !bank_fill |=> core_mem[$past(wr_base)] == $past(cw[0]);
  endproperty
  a_core_commit: assert property (p_core_commit)
    else $error("direct coefficient write missing from core");

  property p_bank_commit;
    @(posedge i_mclk) disable iff (!i_resetn)
    commit && bank_fill
    |=> bank_mem[$past(fill_base) + BI_W'($past(wr_base))] == $past(cw[0]);
  endproperty
  a_bank_commit: assert property (p_bank_commit)
    else $error("bank fill write missing");

  property p_whole_location;
    @(posedge i_mclk) disable iff (!i_resetn)
    commit |-> (is_biquad(wr_sub_reg) && wr_idx_reg == 5'h13)
               || (!is_biquad(wr_sub_reg) && wr_idx_reg == 5'h03);
  endproperty
  a_whole_location: assert property (p_whole_location)
    else $error("coefficient committed before location complete");

  property p_partial_dropped;
    @(posedge i_mclk) disable iff (!i_resetn)
    start_evt || stop_evt |=> wr_idx_reg == 5'h00 && !commit;
  endproperty
  a_partial_dropped: assert property (p_partial_dropped)
    else $error("partial location survived end of transfer");

  property p_auto_reload;
    @(posedge i_mclk) disable iff (!i_resetn)
    $rose(copy_busy_reg) |-> ##[80:90] !copy_busy_reg;
  endproperty
  a_auto_reload: assert property (p_auto_reload)
    else $error("bank reload length wrong");

  property p_headphone;
    @(posedge i_mclk) disable iff (!i_resetn)
    ##1 (o_eq_enable == !$past(i_headphone_sel))
        && (o_drc_enable == o_eq_enable);
  endproperty
  a_headphone: assert property (p_headphone)
    else $error("speaker processing not following headphone select");

  property p_read_advance;
    @(posedge i_mclk) disable iff (!i_resetn)
    rd_ack && rd_idx_reg + 5'h1 == loc_size(rd_sub_reg)
    |=> rd_sub_reg == $past(rd_sub_reg) + 8'h01 && rd_idx_reg == 5'h00;
  endproperty
  a_read_advance: assert property (p_read_advance)
    else $error("read pointer did not move to next location");

endmodule

// ---- icb_master_model.sv ----
`timescale 1ns/1ps
module icb_master_model (
  input  wire logic i_mclk,
  input  wire logic i_sda,
  output logic      o_scl,
  output logic      o_sda_low
);
  initial begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask
  // data moves only while scl is low, held through the high phase
  task automatic bit_io(input logic b, output logic r);
    tick(4);
    o_sda_low = ~b;
    tick(12);
    o_scl = 1'b1;
    tick(12);
    r = i_sda;
    o_scl = 1'b0;
  endtask
  // s0=0: start or repeated start, s0=1: stop
  task automatic cond(input logic s0, input logic s1);
    tick(4);
    o_sda_low = s0;
    tick(12);
    o_scl = 1'b1;
    tick(12);
    o_sda_low = s1;
    tick(12);
    o_scl = s0;
  endtask
  task automatic put(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(b[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask
  task automatic get(input logic last, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      b[i] = r;
    end
    bit_io(last, r);
  endtask
endmodule

// ---- icb_pin_sync.sv ----
`timescale 1ns/1ps
module icb_pin_sync (
  input  wire logic i_mclk,
  input  wire logic i_resetn,
  input  wire logic i_pin,
  output logic      o_level
);

  logic s1_reg;
  logic s2_reg;
  logic s3_reg;

  // bus idles high through the pull-up
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      s1_reg  <= 1'b1;
      s2_reg  <= 1'b1;
      s3_reg  <= 1'b1;
      o_level <= 1'b1;
    end else begin
      s1_reg <= i_pin;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg) begin
        o_level <= s3_reg;
      end
    end
  end

endmodule

// ---- icb_pkg.sv ----
package icb_pkg;

  // ------------------------------------------------------------------
  // bus addressing
  // ------------------------------------------------------------------
  localparam logic [6:0] SLAVE_ADDR   = 7'h36;
  localparam logic [3:0] BITS_PER_ACK = 4'h8;

  // ------------------------------------------------------------------
  // subaddress map
  // ------------------------------------------------------------------
  localparam logic [7:0] SUB_SHUTDOWN  = 8'h05;
  localparam logic [7:0] SUB_VOLUME    = 8'h07;
  localparam logic [7:0] SUB_OSC_TRIM  = 8'h1b;
  localparam logic [7:0] SUB_BANK_CTRL = 8'h50;
  localparam logic [7:0] COEF_FIRST    = 8'h29;
  localparam logic [7:0] BIQUAD_LAST   = 8'h38;
  localparam logic [7:0] MIXER_FIRST   = 8'h39;
  localparam logic [7:0] COEF_LAST     = 8'h3f;

  // ------------------------------------------------------------------
  // location sizes and coefficient store layout
  // ------------------------------------------------------------------
  localparam logic [4:0] BIQUAD_BYTES  = 5'h14;
  localparam logic [4:0] WORD_BYTES    = 5'h04;
  localparam logic [4:0] BYTE_REG      = 5'h01;
  localparam logic [7:0] BIQUAD_WORDS  = 8'h05;
  localparam logic [7:0] MIXER_BASE    = 8'h50;
  localparam int         BQ_MAX_WORDS  = 5;
  localparam int         COEF_WORDS    = 87;
  localparam int         NUM_BANKS     = 3;
  localparam int         BIQUAD_BITS   = 26;

  // ------------------------------------------------------------------
  // field positions and reset values
  // ------------------------------------------------------------------
  localparam int         SHUTDOWN_BIT   = 6;
  localparam logic [7:0] SHUTDOWN_RESET = 8'h40;
  localparam logic [7:0] VOLUME_RESET   = 8'h30;
  localparam logic [7:0] TRIM_RESET     = 8'hff;

  // ------------------------------------------------------------------
  // bank control codes and sample-rate classes
  // ------------------------------------------------------------------
  localparam logic [2:0] BANK_DIRECT = 3'h0;
  localparam logic [2:0] BANK_FILL1  = 3'h1;
  localparam logic [2:0] BANK_FILL3  = 3'h3;
  localparam logic [2:0] BANK_AUTO   = 3'h4;
  localparam logic [1:0] RATE_32K    = 2'h0;
  localparam logic [1:0] RATE_44_48K = 2'h1;

  typedef enum logic [5:0] {
    ST_IDLE   = 6'b000001,
    ST_RX     = 6'b000010,
    ST_ACK_TX = 6'b000100,
    ST_TX     = 6'b001000,
    ST_ACK_RX = 6'b010000,
    ST_WAIT   = 6'b100000
  } icb_state_type;

endpackage
